/* File: rtl/sdram_timing_pkg.sv */
// Package: shared constants for the SDRAM command-timing pair
// Assumes: one 25 MHz clock, both ends in the same clock domain
package sdram_timing_pkg;

  // Clock period
  localparam int unsigned CLK_PERIOD_PS = 40000;

  // Speed grade nanosecond figures (fast grade used)
  localparam int unsigned T_RAS_MIN_NS = 42;
  localparam int unsigned T_RAS_MAX_NS = 120000;
  localparam int unsigned T_RP_NS      = 18;
  localparam int unsigned T_RC_NS      = 60;
  localparam int unsigned T_RFC_NS     = 60;
  localparam int unsigned T_RCD_NS     = 18;
  localparam int unsigned T_RRD_NS     = 12;
  localparam int unsigned T_XSR_NS     = 70;
  localparam int unsigned T_WR_NS      = 12;
  localparam int unsigned T_REF_MS     = 64;
  localparam int unsigned REF_ROWS     = 4096;

  // Clock-count minimums
  localparam int unsigned T_MRD_CK = 2;
  localparam int unsigned T_DPL_CK = 2;
  localparam int unsigned T_XSR_MIN_CK = 2;
  localparam int unsigned T_DQZ_CK = 2;

  // Round-up and round-down conversions to cycles
  function automatic int unsigned ns_up(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns_up

  function automatic int unsigned mx(input int unsigned a, input int unsigned b);
    return (a > b) ? a : b;
  endfunction : mx

  localparam int unsigned RAS_MIN_CYC = ns_up(T_RAS_MIN_NS);
  localparam int unsigned RAS_MAX_CYC = (T_RAS_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned RP_CYC      = ns_up(T_RP_NS);
  localparam int unsigned RC_CYC      = ns_up(T_RC_NS);
  localparam int unsigned RFC_CYC     = ns_up(T_RFC_NS);
  localparam int unsigned RCD_CYC     = ns_up(T_RCD_NS);
  localparam int unsigned RRD_CYC     = ns_up(T_RRD_NS);
  localparam int unsigned XSR_CYC     = mx(ns_up(T_XSR_NS), T_XSR_MIN_CK);
  localparam int unsigned WR_CYC      = mx(ns_up(T_WR_NS), T_DPL_CK);
  // Refresh interval per row, in cycles (64 ms / 4096 rows)
  localparam int unsigned REF_INT_CYC =
    (T_REF_MS * 1000 * 1000) / (REF_ROWS * (CLK_PERIOD_PS / 1000));

  // Command codes {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'hF,
    CMD_NOP     = 4'h7,
    CMD_ACT     = 4'h3,
    CMD_READ    = 4'h5,
    CMD_WRITE   = 4'h4,
    CMD_STOP    = 4'h6,
    CMD_PRE     = 4'h2,
    CMD_REF     = 4'h1,
    CMD_MRS     = 4'h0
  } cmd_t;

  localparam int unsigned DW = 32;
  localparam int unsigned NB = 4;
  localparam logic [1:0] RL_RESET = 2'h3;
  localparam logic [3:0] CNT_W1 = 4'h1;

endpackage : sdram_timing_pkg

/* File: rtl/sdram_link_if.sv */
// Interface: command and data pins between controller and SDRAM end
// Assumes: both ends share clk_i; data bus resolved here from enables
`timescale 1ns/1ps
interface sdram_link_if;
  import sdram_timing_pkg::*;
  logic          cke;
  cmd_t          cmd;
  logic [1:0]    bank;
  logic [11:0]   addr;
  logic [NB-1:0] dqm;
  logic [DW-1:0] dq_ctl;
  logic          dq_ctl_oe;
  logic [DW-1:0] dq_mem;
  logic [NB-1:0] dq_mem_oe;
  logic [DW-1:0] dq;

  // Wire level from whoever drives each byte
  always_comb begin
    dq = dq_ctl_oe ? dq_ctl : '0;
    for (int b = 0; b < NB; b++) begin
      if (dq_mem_oe[b]) begin
        dq[b*8 +: 8] = dq_mem[b*8 +: 8];
      end
    end
  end

  modport ctl (output cke, cmd, bank, addr, dqm, dq_ctl, dq_ctl_oe, input dq);
  modport mem (input cke, cmd, bank, addr, dqm, dq, output dq_mem, dq_mem_oe);
endinterface : sdram_link_if

/* File: rtl/sdram_mem_end.sv */
// SDRAM end: clock suspend, byte masks, write capture, read output timing
// Assumes: controller keeps command spacing; small array stands for the core
`timescale 1ns/1ps

// Timing rules of the link between the controller end and this end
// RULE1 - Controller keeps row open 42ns to 120us
// RULE2 - Same-bank activates spaced 60ns; refresh too
// RULE3 - Controller waits 18ns activate to column
// RULE4 - Controller refreshes 4096 rows within 64ms (refreshes here come 391 or more clocks apart, over 64ms for 4096)
// RULE5 - Different-bank activates spaced at least 12ns
// RULE6 - Activate waits 70ns after self refresh
// RULE7 - Column commands accepted every clock
// RULE8 - Clock enable low suspends one clock later
// RULE9 - Clock enable high resumes one clock later
// RULE10 - Write byte mask applies with zero latency
// RULE11 - Read byte mask floats output two clocks later
// RULE12 - First write word captured with command
// RULE13 - Auto-precharge write waits latency-based clocks
// RULE14 - Two clocks last write data to precharge
// RULE15 - Burst stop one clock after write data
// RULE16 - New column command one clock after data
// RULE17 - Two clocks after mode load before activate
// RULE18 - Precharge floats read data after read latency
// RULE19 - Only no-ops during refresh
// RULE20 - Controller rounds nanoseconds up to cycles
module sdram_mem_end
  import sdram_timing_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  sdram_link_if.mem       link,
  input  wire logic [1:0] read_latency_setting_i,
  output logic            suspended_o,
  output logic            write_seen_o
);

  ////////////////////////////////////////////////////////////////////////
  // Storage and pipeline state
  ////////////////////////////////////////////////////////////////////////

  // One row's worth of columns; the row address is not modelled
  localparam int unsigned DEPTH = 256;

  logic [DW-1:0] mem_r [DEPTH];   // Column words of the open row
  logic          clk_on_r;        // Internal clock running
  logic [7:0]    col_r;           // Last column addressed
  logic [1:0]    rd_pipe_r;       // Read command, one and two edges ago
  logic [DW-1:0] rd_data_r [2];   // Read word, one and two edges ago
  logic [NB-1:0] dqm_d1_r;        // Byte mask taken at the previous edge
  logic [NB-1:0] oe_r;            // Byte drive enables
  logic [DW-1:0] out_r;           // Word shown on the data pins
  logic          cmd_live;        // Command sampled at this edge counts
  logic          wr_now;          // Write command at this edge
  logic          rd_now;          // Read command at this edge
  logic          rd_sel;          // Read word due on the pins next cycle
  logic [DW-1:0] rd_word;         // Word due on the pins next cycle
  logic [7:0]    col_cur;         // Column used at this edge

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////////////

  // True when the sampled command is the one asked for
  function automatic logic cmd_is(input cmd_t seen, input cmd_t want);
    return seen == want;
  endfunction : cmd_is

  // Latency setting folded to 1..3; a setting of 0 is taken as 3
  function automatic logic [1:0] lat_of(input logic [1:0] setting);
    return (setting == 2'h0) ? 2'h3 : setting;
  endfunction : lat_of

  ////////////////////////////////////////////////////////////////////////
  // Clock suspend tracking
  ////////////////////////////////////////////////////////////////////////

  // RULE8 suspend after sample
  // RULE9 resume after sample
  // The enable taken at one edge gates every command from the next edge on,
  // so a command that arrives while the enable was low is ignored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_on_r <= 1'b1;
    end else begin
      clk_on_r <= link.cke;
    end
  end

  // Commands and pipelines advance only while the internal clock runs
  assign cmd_live = clk_on_r;
  // RULE7 column every clock
  assign wr_now   = cmd_live && cmd_is(link.cmd, CMD_WRITE);
  assign rd_now   = cmd_live && cmd_is(link.cmd, CMD_READ);
  assign col_cur  = (wr_now || rd_now) ? link.addr[7:0] : col_r;

  // Last column addressed; idle edges read it again, which is harmless
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      col_r <= 8'h00;
    end else if (wr_now || rd_now) begin
      col_r <= link.addr[7:0];
    end
  end

  // Status flags for the host side
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_seen_o <= 1'b0;
      suspended_o  <= 1'b0;
    end else begin
      write_seen_o <= wr_now;
      suspended_o  <= !link.cke;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write capture
  ////////////////////////////////////////////////////////////////////////

  // RULE12 data with command
  // RULE10 mask zero latency
  // One word per write command; bytes masked at the same edge keep the
  // old contents of the row
  always_ff @(posedge clk_i) begin
    if (wr_now) begin
      for (int b = 0; b < NB; b++) begin
        if (!link.dqm[b]) begin
          mem_r[col_cur][b*8 +: 8] <= link.dq[b*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read pipeline
  ////////////////////////////////////////////////////////////////////////

  // RULE11 mask two clocks
  // The mask is taken one edge before the drive edge, so a byte masked at
  // one edge is off the pins at the edge two clocks later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_pipe_r <= 2'h0;
      dqm_d1_r  <= '1;
    end else if (cmd_live) begin
      rd_pipe_r <= {rd_pipe_r[0], rd_now};
      dqm_d1_r  <= link.dqm;
    end
  end

  // Read words follow the command down the same stages
  always_ff @(posedge clk_i) begin
    if (cmd_live) begin
      rd_data_r[0] <= mem_r[col_cur];
      rd_data_r[1] <= rd_data_r[0];
    end
  end

  // Pick the stage that meets the latency setting
  always_comb begin
    rd_sel  = 1'b0;
    rd_word = '0;
    case (lat_of(read_latency_setting_i))
      2'h1: begin
        rd_sel  = rd_now;
        rd_word = mem_r[col_cur];
      end
      2'h2: begin
        rd_sel  = rd_pipe_r[0];
        rd_word = rd_data_r[0];
      end
      default: begin
        rd_sel  = rd_pipe_r[1];
        rd_word = rd_data_r[1];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drive
  ////////////////////////////////////////////////////////////////////////

  // RULE18 precharge ends read
  // Reads are single words, so no burst outlives a precharge and the
  // pins float as soon as the last read word has been shown
  // RULE11 masked bytes float
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_r <= '0;
    end else if (cmd_live) begin
      oe_r <= {NB{rd_sel}} & ~dqm_d1_r;
    end
  end

  // Data word, held while the clock is suspended
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_r <= '0;
    end else if (cmd_live) begin
      out_r <= rd_word;
    end
  end

  // Pins of the shared data bus
  assign link.dq_mem    = out_r;
  assign link.dq_mem_oe = oe_r;

endmodule : sdram_mem_end

/* File: rtl/sdram_ctl_end.sv */
// Controller end: issues commands with spacing held to cycle counts
// Assumes: user pushes word requests through a two-entry buffer
`timescale 1ns/1ps

module sdram_ctl_end
  import sdram_timing_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  sdram_link_if.ctl          link,
  input  wire logic          req_valid_i,
  input  wire logic          req_write_i,
  input  wire logic [7:0]    req_col_i,
  input  wire logic [DW-1:0] req_data_i,
  output logic               req_ready_o,
  output logic               rd_valid_o,
  output logic [DW-1:0]      rd_data_o
);

  typedef enum logic [5:0] {
    ST_MRS  = 6'h01, ST_IDLE = 6'h02, ST_ACT = 6'h04,
    ST_COL  = 6'h08, ST_PRE  = 6'h10, ST_REF = 6'h20
  } st_t;

  st_t           st_r;
  logic [15:0]   wait_r;
  logic [15:0]   ras_r;
  logic [15:0]   ref_r;
  logic [2:0]    rdp_r;
  // Two-entry buffer
  logic [40:0]   buf_r [2];
  logic [1:0]    cnt_r;
  logic          wp_r, rp_r;
  logic          pop;
  logic          turn;
  logic          issue_ok;

  // Turnaround: no write while read data may still be on the shared bus
  assign turn = (cnt_r != 2'h0) && buf_r[rp_r][40]
                && ((link.cmd == CMD_READ) || (rdp_r[1:0] != 2'h0));
  // Column issue: entry waiting, row still in time, bus free
  assign issue_ok = (st_r == ST_COL) && (wait_r == 16'h0) && (cnt_r != 2'h0)
                    && (ref_r < 16'(REF_INT_CYC)) && (ras_r < 16'(RAS_MAX_CYC))
                    && !turn;
  // An entry leaves the buffer only when its command is issued
  assign pop = issue_ok;

  // Buffer storage, written on an accepted request
  always_ff @(posedge clk_i) begin
    if (req_valid_i && req_ready_o) begin
      buf_r[wp_r] <= {req_write_i, req_col_i, req_data_i};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 2'h0; wp_r <= 1'b0; rp_r <= 1'b0; req_ready_o <= 1'b1;
    end else begin
      if (req_valid_i && req_ready_o) begin
        wp_r <= ~wp_r;
      end
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, req_valid_i && req_ready_o} - {1'b0, pop};
      req_ready_o <= (cnt_r + {1'b0, req_valid_i && req_ready_o} - {1'b0, pop}) < 2'h2;
    end
  end

  // Command sequencer with spacing counters (RULE20 rounding in package)
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_MRS; wait_r <= 16'h0; ras_r <= 16'h0; ref_r <= 16'h0;
      link.cmd <= CMD_NOP; link.cke <= 1'b1; link.dqm <= '1;
      link.dq_ctl_oe <= 1'b0; link.dq_ctl <= '0; link.bank <= 2'h0; link.addr <= '0;
    end else begin
      link.cmd <= CMD_NOP;
      link.dq_ctl_oe <= 1'b0;
      // RULE11 bytes open the cycle after a read; a write opens them with its command below
      link.dqm <= {NB{link.cmd != CMD_READ}};
      ref_r <= ref_r + 16'h1;
      ras_r <= ras_r + 16'h1;
      if (wait_r != 16'h0) wait_r <= wait_r - 16'h1;
      case (st_r)
        ST_MRS: begin
          link.cmd <= CMD_MRS; link.addr <= {10'h0, RL_RESET};
          // RULE17 mode load gap
          wait_r <= 16'(T_MRD_CK); st_r <= ST_IDLE;
        end
        ST_IDLE: if (wait_r == 16'h0) begin
          if (!link.cke) begin
            // RULE8 RULE9 wake the far end a clock before use
            if (cnt_r != 2'h0 || ref_r >= 16'(REF_INT_CYC)) begin
              link.cke <= 1'b1;
            end
          // RULE4 periodic refresh
          end else if (ref_r >= 16'(REF_INT_CYC)) begin
            link.cmd <= CMD_REF; ref_r <= 16'h0;
            // RULE2 RULE19 refresh period
            wait_r <= 16'(RFC_CYC); st_r <= ST_REF;
          end else if (cnt_r != 2'h0) begin
            link.cmd <= CMD_ACT; ras_r <= 16'h0;
            // RULE3 RULE5 activate spacing
            wait_r <= 16'(mx(RCD_CYC, RRD_CYC) - 1); st_r <= ST_COL;
          end else begin
            // Nothing queued: let the far end sleep
            link.cke <= 1'b0;
          end
        end
        ST_REF: if (wait_r <= 16'h1) st_r <= ST_IDLE;
        ST_COL: if (wait_r == 16'h0) begin
          // RULE6 RULE13 RULE15 no self refresh, auto precharge or stop used
          if (issue_ok) begin
            // RULE7 RULE12 RULE16 reads back to back; a write holds off the next column for WR_CYC
            link.cmd <= buf_r[rp_r][40] ? CMD_WRITE : CMD_READ;
            link.addr <= {4'h0, buf_r[rp_r][39:32]};
            link.dq_ctl <= buf_r[rp_r][31:0];
            link.dq_ctl_oe <= buf_r[rp_r][40];
            if (buf_r[rp_r][40]) begin
              wait_r   <= 16'(WR_CYC);
              link.dqm <= '0;
            end
          end else if (ras_r >= 16'(RAS_MIN_CYC) && !turn) begin
            // RULE1 RULE14 open time and recovery
            link.cmd <= CMD_PRE; wait_r <= 16'(mx(RP_CYC, RC_CYC - RAS_MIN_CYC));
            st_r <= ST_PRE;
          end
        end
        ST_PRE: if (wait_r <= 16'h1) st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Read return after fixed latency
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdp_r <= 3'h0; rd_valid_o <= 1'b0; rd_data_o <= '0;
    end else begin
      rdp_r <= {rdp_r[1:0], link.cmd == CMD_READ};
      rd_valid_o <= rdp_r[2];
      rd_data_o <= link.dq;
    end
  end

endmodule : sdram_ctl_end

/* File: verification/sdram_link_properties.sv */
// Checker: command spacing and data-bus timing on the link
// Assumes: one clock, latency setting 3, instanced beside the interface
`timescale 1ns/1ps
module sdram_link_properties
  import sdram_timing_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire cmd_t          cmd,
  input wire logic [1:0]    bank,
  input wire logic [NB-1:0] dqm,
  input wire logic          dq_ctl_oe,
  input wire logic [NB-1:0] dq_mem_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // Command spacing held by the controller end
  chk_mode_load_gap: assert property (cmd == CMD_MRS |=> !(cmd inside {CMD_ACT, CMD_REF}))
    else $error("activate or refresh too soon after mode load");
  chk_row_open_min: assert property (cmd == CMD_ACT |=> !(cmd == CMD_PRE && bank == $past(bank)))
    else $error("row closed too soon");
  chk_same_bank_act: assert property (cmd == CMD_ACT |=> !(cmd == CMD_ACT && bank == $past(bank)))
    else $error("same bank activated too soon");
  chk_refresh_busy_gap: assert property (cmd == CMD_REF |=> cmd inside {CMD_NOP, CMD_INHIBIT})
    else $error("command during refresh");
  chk_write_recovery: assert property (cmd == CMD_WRITE |=> !(cmd == CMD_PRE && bank == $past(bank)))
    else $error("precharge too soon after write data");
  ////////////////////////////////////////////////////////////////
  // Data-bus timing of both ends
  chk_write_data_now: assert property (cmd == CMD_WRITE |-> dq_ctl_oe && dq_mem_oe == '0)
    else $error("write data not driven with command");
  chk_read_mask_float: assert property ((dq_mem_oe & $past(dqm, 2)) == '0)
    else $error("masked read byte driven");
  chk_read_byte_out: assert property (cmd == CMD_READ |-> ##3 dq_mem_oe == ~$past(dqm, 2))
    else $error("read data bytes wrong at latency 3");
  chk_precharge_float: assert property (cmd == CMD_PRE |-> ##3 dq_mem_oe == '0)
    else $error("read data not floated after precharge");
endmodule : sdram_link_properties

/* File: verification/tb_top.sv */
// Testbench: controller end and SDRAM end joined by the link
// Assumes: 25 MHz clock, latency setting 3, inputs driven 1 ns after edge
`timescale 1ns/1ps
module tb_top;
  import sdram_timing_pkg::*;
  logic          clk_i;
  logic          rst_i;
  logic          req_valid_i;
  logic          req_write_i;
  logic [7:0]    req_col_i;
  logic [DW-1:0] req_data_i;
  logic          req_ready_o;
  logic          rd_valid_o;
  logic [DW-1:0] rd_data_o;
  logic          suspended_o;
  logic          write_seen_o;
  logic          wr_prev;
  logic          saw_full;
  logic          saw_sleep;
  logic          cke_prev;
  int            failures;
  int            samples_checked;
  logic [DW-1:0] rq[$];
  logic [DW-1:0] wq[$];
  sdram_link_if link ();
  sdram_ctl_end i_sdram_ctl_end (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_col_i(req_col_i),
    .req_data_i(req_data_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o));
  sdram_mem_end i_sdram_mem_end (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .read_latency_setting_i(2'h3), .suspended_o(suspended_o), .write_seen_o(write_seen_o));
  sdram_link_properties i_sdram_link_properties (.clk_i(clk_i), .rst_i(rst_i),
    .cmd(link.cmd), .bank(link.bank), .dqm(link.dqm), .dq_ctl_oe(link.dq_ctl_oe),
    .dq_mem_oe(link.dq_mem_oe));
  ////////////////////////////////////////////////////////////////
  // Clock generation
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic final_report;
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Push one request; valid held until ready seen at an edge
  task automatic push(input logic w, input logic [7:0] c, input logic [DW-1:0] d);
    int n;
    n = 0;
    req_valid_i = 1'b1;
    req_write_i = w;
    req_col_i = c;
    req_data_i = d;
    if (w) wq.push_back(d);
    while (req_ready_o !== 1'b1 && n < 200) begin
      saw_full = 1'b1;
      @(posedge clk_i) #1 n++;
    end
    if (n == 200) begin
      failures++;
      final_report();
    end
    @(posedge clk_i) #1;
  endtask : push
  // Release valid, then wait for read words under a bound
  task automatic drain(input int cnt);
    int n;
    req_valid_i = 1'b0;
    for (n = 0; n < 2000 && rq.size() < cnt; n++) @(posedge clk_i) #1;
    check(rq.size(), cnt);
  endtask : drain
  ////////////////////////////////////////////////////////////////
  // Link watch: write word on the wire, write pulse, read capture
  always @(negedge clk_i) begin
    if (!rst_i) begin
      // suspend follows the enable sampled at the last edge
      check(suspended_o, cke_prev !== 1'b1);
      if (suspended_o === 1'b1) saw_sleep = 1'b1;
      check(write_seen_o, wr_prev);
      if (link.cmd === CMD_WRITE && wq.size() > 0) check(link.dq, wq.pop_front());
      if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
    end
    wr_prev = (link.cmd === CMD_WRITE);
    cke_prev = link.cke;
  end
  // Single word written then read back
  task automatic single_word;
    push(1'b1, 8'h05, 32'h1234ABCD);
    push(1'b0, 8'h05, 32'h0);
    drain(1);
    check(rq.pop_front(), 32'h1234ABCD);
  endtask : single_word
  // Back-to-back words at edge columns, buffer filled meanwhile
  task automatic burst_words;
    logic [7:0] cols[4];
    cols = '{8'h00, 8'h01, 8'hFE, 8'hFF};
    saw_full = 1'b0;
    foreach (cols[i]) push(1'b1, cols[i], {24'hC0FFEE, cols[i]});
    foreach (cols[i]) push(1'b0, cols[i], 32'h0);
    drain(4);
    check(saw_full, 1'b1);
    foreach (cols[i]) check(rq.pop_front(), {24'hC0FFEE, cols[i]});
  endtask : burst_words
  initial begin
    failures = 0;
    samples_checked = 0;
    wr_prev = 1'b0;
    saw_full = 1'b0;
    saw_sleep = 1'b0;
    cke_prev = 1'b1;
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_col_i = 8'h00;
    req_data_i = 32'h0;
    repeat (5) @(posedge clk_i);
    check(link.dq_mem_oe, 4'h0);
    #1 rst_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #1 single_word();
    burst_words();
    repeat (900) @(posedge clk_i);
    check(saw_sleep, 1'b1);
    #1 burst_words();
    final_report();
  end
  // Watchdog against a hung run
  initial begin
    #4000000;
    failures++;
    final_report();
  end
endmodule : tb_top
